// [rtl/i2c_master_regs.svh]
// Register offsets, field positions, reset values and timing counts of the I2C master
`ifndef I2C_MASTER_REGS_SVH
`define I2C_MASTER_REGS_SVH
`define TX_BUF_ADDR       8'h9a
`define RX_BUF_ADDR       8'h9b
`define MODE_ADDR         8'he8
`define SLAVE_ADDR_ADDR   8'he9
`define STATUS_ADDR       8'hea
`define MODE_ENABLE_BIT   7
`define MODE_RATE_HI      6
`define MODE_RATE_LO      5
`define MODE_COUNT_HI     4
`define ST_BUSY_BIT       7
`define ST_NOACK_BIT      6
`define ST_RXPEND_BIT     5
`define ST_TXEMPTY_BIT    4
`define ST_FIFO_HI        3
`define ST_FIFO_LO        2
`define ST_TXWR_ERR_BIT   0
`define MODE_RESET        8'h00
`define SLAVE_ADDR_RESET  8'h00
`define RX_BUF_RESET      8'h00
`define SCL_BASE_DIV      16
`define QUARTERS_PER_BIT  4
`define REF_CORE_HZ       4096000
`define REF_FAST_HZ       256000
`define REF_STD_HZ        32000
`endif

// [rtl/i2c_master_pkg.sv]
// Types shared by the I2C master files
package i2c_master_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} master_state_t;
  typedef logic [1:0] rate_sel_t;
endpackage : i2c_master_pkg

// [rtl/i2c_rate_divider.sv]
// Quarter-bit tick divider for the serial clock
`timescale 1ns/1ns
`include "i2c_master_regs.svh"
module i2c_rate_divider
  import i2c_master_pkg::*;
#(
  parameter int BASE_DIV = `SCL_BASE_DIV
) (
  input  wire logic      clock,
  input  wire logic      reset,
  input  wire rate_sel_t rate,
  input  wire logic      run,
  output logic           tick
);
  logic [7:0] count_q;

  function automatic logic [7:0] quarter_len(input rate_sel_t r);
    quarter_len = 8'((BASE_DIV / `QUARTERS_PER_BIT) << r);
  endfunction : quarter_len

  // core clock over 16 times two to the rate
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= 8'h00;
      tick    <= 1'b0;
    end else if (!run) begin
      count_q <= 8'h00;
      tick    <= 1'b0;
    end else if (count_q >= quarter_len(rate) - 8'h01) begin
      count_q <= 8'h00;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule : i2c_rate_divider

// [rtl/i2c_hardware_master.sv]
// I2C hardware master sharing pins and registers with the SPI port
`timescale 1ns/1ns
`include "i2c_master_regs.svh"
module i2c_hardware_master
  import i2c_master_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       serial_port_select,
  input  wire logic       spi_sclk_out,
  input  wire logic       spi_sclk_oe,
  input  wire logic       spi_mosi_out,
  input  wire logic       spi_mosi_oe,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe
);
  logic [7:0]    mode_q, addr_q, rx_buf_q, tx_buf_q, shift_q;
  logic          tx_full_q, start_pend_q, noack_q, rxpend_q, txempty_q, txwr_err_q;
  logic [2:0]    scl_s_q, sda_s_q;
  logic          scl_f_q, sda_f_q, scl_low_q, sda_low_q, lost_q, ack_q;
  logic [1:0]    phase_q;
  logic [3:0]    bit_cnt_q;
  logic [4:0]    rx_left_q;
  logic          is_addr_q;
  master_state_t state_q;
  logic          tick, enabled, sending, drive_bit, byte_end, load_tx, set_noack, set_rx;
  logic          wr_tx, wr_mode, wr_addr, wr_stat, stall;

  // register decode at the shared locations
  always_comb begin
    wr_tx   = 1'b0;
    wr_mode = 1'b0;
    wr_addr = 1'b0;
    wr_stat = 1'b0;
    if (sfr_wr && sfr_addr == `TX_BUF_ADDR) begin
      wr_tx = 1'b1;
    end else if (sfr_wr && sfr_addr == `MODE_ADDR) begin
      wr_mode = 1'b1;
    end else if (sfr_wr && sfr_addr == `SLAVE_ADDR_ADDR) begin
      wr_addr = 1'b1;
    end else if (sfr_wr && sfr_addr == `STATUS_ADDR) begin
      wr_stat = 1'b1;
    end
  end

  assign enabled = mode_q[`MODE_ENABLE_BIT] && serial_port_select;
  // bit 0 of the address byte is the direction
  assign sending = is_addr_q || !addr_q[0];
  assign drive_bit = (bit_cnt_q < 4'd8) ? (sending ? shift_q[7] : 1'b1)
                                        : (sending ? 1'b1 : (rx_left_q == 5'd0));
  // Clock-high wait sits just before the fall and before the stop's data release: pin sync lags a whole quarter at the fastest rate
  assign stall = !scl_f_q && ((state_q == ST_BITS && phase_q == 2'd3) || (state_q == ST_STOP && phase_q == 2'd2));
  assign byte_end = tick && !stall && state_q == ST_BITS && phase_q == 2'd3 && bit_cnt_q == 4'd8;
  // next write byte comes from the transmit buffer
  assign load_tx = byte_end && !lost_q && sending && ack_q && !addr_q[0] && tx_full_q;
  // missing acknowledge detected at byte end
  assign set_noack = byte_end && !lost_q && sending && !ack_q;
  assign set_rx = byte_end && !lost_q && !sending;

  // tick is a quarter of the serial clock period
  // 4 cycles a quarter at rate 0, 32 at rate 3
  i2c_rate_divider #(.BASE_DIV(`SCL_BASE_DIV)) u_div (
    .clock (clock),
    .reset (reset),
    .rate  (mode_q[`MODE_RATE_HI:`MODE_RATE_LO]),
    .run   (state_q != ST_IDLE || start_pend_q),
    .tick  (tick)
  );

  // Pins are outside our clock; a level counts once stages two and three agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], serial_data_pin_in};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_q <= `MODE_RESET;
      addr_q <= `SLAVE_ADDR_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= sfr_wdata;
      end
      if (wr_addr) begin
        addr_q <= sfr_wdata;
      end
    end
  end

  // address write launches a transfer when enabled
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      start_pend_q <= 1'b0;
    end else if (wr_addr && enabled) begin
      start_pend_q <= 1'b1;
    end else if (state_q == ST_START || !enabled) begin
      start_pend_q <= 1'b0;
    end
  end

  // A write into a full buffer is refused, the byte is lost and the error flag tells why
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_buf_q  <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (wr_tx && !tx_full_q) begin
      tx_buf_q  <= sfr_wdata;
      tx_full_q <= 1'b1;
    end else if (load_tx) begin
      tx_full_q <= 1'b0;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      noack_q    <= 1'b0;
      rxpend_q   <= 1'b0;
      txempty_q  <= 1'b0;
      txwr_err_q <= 1'b0;
    end else begin
      noack_q    <= set_noack || (noack_q && !(wr_stat && !sfr_wdata[`ST_NOACK_BIT]));
      rxpend_q   <= set_rx || (rxpend_q && !(wr_stat && !sfr_wdata[`ST_RXPEND_BIT]));
      txempty_q  <= load_tx || (txempty_q && !(wr_stat && !sfr_wdata[`ST_TXEMPTY_BIT]));
      txwr_err_q <= (wr_tx && tx_full_q) || (txwr_err_q && !(wr_stat && !sfr_wdata[`ST_TXWR_ERR_BIT]));
    end
  end

  // start, address, data on ack, stop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      phase_q   <= 2'd0;
      bit_cnt_q <= 4'd0;
      shift_q   <= 8'h00;
      rx_left_q <= 5'd0;
      is_addr_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      lost_q    <= 1'b0;
      ack_q     <= 1'b0;
      rx_buf_q  <= `RX_BUF_RESET;
    end else if (tick && !stall) begin
      phase_q <= phase_q + 2'd1;
      case (state_q)
        ST_IDLE: begin
          phase_q <= 2'd0;
          // only an idle bus may be claimed
          if (start_pend_q && scl_f_q && sda_f_q) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (phase_q == 2'd1) begin
            sda_low_q <= 1'b1;
          end else if (phase_q == 2'd2) begin
            scl_low_q <= 1'b1;
            shift_q   <= addr_q;
            is_addr_q <= 1'b1;
            lost_q    <= 1'b0;
            bit_cnt_q <= 4'd0;
            rx_left_q <= mode_q[`MODE_COUNT_HI:0];
            state_q   <= ST_BITS;
            phase_q   <= 2'd0;
          end
        end
        ST_BITS: begin
          if (phase_q == 2'd0) begin
            sda_low_q <= !drive_bit;
          end else if (phase_q == 2'd1) begin
            scl_low_q <= 1'b0;
          end else if (phase_q == 2'd2) begin
            if (bit_cnt_q < 4'd8) begin
              shift_q <= {shift_q[6:0], sda_f_q};
            end else begin
              ack_q <= !sda_f_q;
            end
            // a released line seen low means another master won
            if (drive_bit && !sda_f_q && (bit_cnt_q < 4'd8) == sending) begin
              lost_q <= 1'b1;
            end
          end else begin
            scl_low_q <= 1'b1;
            bit_cnt_q <= bit_cnt_q + 4'd1;
            if (bit_cnt_q == 4'd8) begin
              bit_cnt_q <= 4'd0;
              is_addr_q <= 1'b0;
              if (lost_q) begin
                scl_low_q <= 1'b0;
                sda_low_q <= 1'b0;
                state_q   <= ST_IDLE;
              end else if (sending) begin
                // read continues after the address, write needs a full buffer
                if (!ack_q) begin
                  state_q <= ST_STOP;
                end else if (addr_q[0]) begin
                  shift_q <= 8'hff;
                end else if (tx_full_q) begin
                  shift_q <= tx_buf_q;
                end else begin
                  state_q <= ST_STOP;
                end
              end else begin
                // stop after count plus one bytes
                rx_buf_q <= shift_q;
                if (rx_left_q == 5'd0) begin
                  state_q <= ST_STOP;
                end else begin
                  rx_left_q <= rx_left_q - 5'd1;
                end
              end
            end
          end
        end
        ST_STOP: begin
          if (phase_q == 2'd0) begin
            sda_low_q <= 1'b1;
          end else if (phase_q == 2'd1) begin
            scl_low_q <= 1'b0;
          end else if (phase_q == 2'd2) begin
            sda_low_q <= 1'b0;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // read data registered; unmapped and write-only offsets read zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `RX_BUF_ADDR) begin
        sfr_rdata <= rx_buf_q;
      end else if (sfr_addr == `MODE_ADDR) begin
        sfr_rdata <= mode_q;
      end else if (sfr_addr == `SLAVE_ADDR_ADDR) begin
        sfr_rdata <= addr_q;
      end else if (sfr_addr == `STATUS_ADDR) begin
        sfr_rdata <= {state_q != ST_IDLE || start_pend_q, noack_q, rxpend_q, txempty_q,
                      {2{addr_q[0] ? rxpend_q : tx_full_q}}, 1'b0, txwr_err_q};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // I2C side only ever pulls low
  assign scl_out             = serial_port_select ? 1'b0 : spi_sclk_out;
  assign scl_oe              = serial_port_select ? scl_low_q : spi_sclk_oe;
  assign serial_data_pin_out = serial_port_select ? 1'b0 : spi_mosi_out;
  assign serial_data_pin_oe  = serial_port_select ? sda_low_q : spi_mosi_oe;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_pin_owner_spi: assert property (!serial_port_select |-> scl_oe == spi_sclk_oe && serial_data_pin_oe == spi_mosi_oe)
    else $error("SPI pins not passed through");
  chk_open_drain_low: assert property (serial_port_select |-> !scl_out && !serial_data_pin_out)
    else $error("I2C drove a pin high");
  chk_start_bus_idle: assert property (state_q == ST_IDLE ##1 state_q == ST_START |-> $past(scl_f_q && sda_f_q))
    else $error("Start on a busy bus");
  chk_disabled_no_launch: assert property (wr_addr && !enabled && state_q == ST_IDLE |=> !start_pend_q && state_q == ST_IDLE)
    else $error("Disabled address write launched");
  chk_enabled_launch: assert property (wr_addr && enabled |=> start_pend_q || state_q != ST_IDLE)
    else $error("Enabled address write did not launch");
  chk_tick_fast_gap: assert property (tick |=> !tick [*3])
    else $error("Quarter tick shorter than four cycles");
  chk_tick_slow_gap: assert property (tick && mode_q[`MODE_RATE_HI:`MODE_RATE_LO] == 2'd3 && !wr_mode |=> !tick [*8])
    else $error("Slowest rate tick too fast");
  chk_noack_stops: assert property (set_noack |=> state_q == ST_STOP && noack_q)
    else $error("No-acknowledge did not stop");
  chk_rx_flag_set: assert property (set_rx |=> rxpend_q && rx_buf_q == $past(shift_q))
    else $error("Received byte not flagged");
  chk_tx_flag_set: assert property (load_tx |=> txempty_q && !tx_full_q && shift_q == $past(tx_buf_q))
    else $error("Transmit buffer load not flagged");
  chk_addr_loaded: assert property (tick && state_q == ST_START && phase_q == 2'd2 |=> shift_q == addr_q && is_addr_q)
    else $error("Address byte not loaded");
  chk_rx_count_stop: assert property (set_rx && rx_left_q == 5'd0 |=> state_q == ST_STOP)
    else $error("Read did not stop at count");

  cov_write_byte: cover property (load_tx);
  cov_read_byte: cover property (set_rx ##[1:1000] state_q == ST_STOP);
  cov_noack: cover property (set_noack);
endmodule : i2c_hardware_master

// [sim/i2c_slave_model.sv]
// Behavioural I2C slave answering the master across the open-drain wires
`timescale 1ns/1ns
module i2c_slave_model #(
  parameter logic [6:0] SLAVE_ID   = 7'h3a,
  parameter int         STRETCH_NS = 300
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic       stretch,
  input  wire logic [7:0] rd_data,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic      [7:0] adr_byte,
  output logic      [7:0] wr_byte,
  output int              nbytes,
  output int              starts,
  output int              stops
);
  logic [7:0] sh;
  int         bc;
  logic       act, adr_ph, rdon, hit;
  initial begin
    {scl_oe, sda_oe, act, adr_ph, rdon, hit} = 6'h00;
    {sh, adr_byte, wr_byte} = 24'h000000;
    {bc, nbytes, starts, stops} = 128'd0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      starts++;
      {act, adr_ph, rdon, sda_oe} = 4'b1100;
      bc = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1 && act) begin
      stops++;
      {act, sda_oe} = 2'b00;
    end
  end
  // master nack ends a read; an ack asks for another byte
  always @(posedge scl) begin
    if (act) begin
      if (bc < 8) sh = {sh[6:0], sda};
      if (bc == 8 && rdon) begin
        nbytes++;
        rdon = (sda === 1'b0);
      end
      bc++;
    end
  end
  // only ever pulls low; released lines float to the pull-up
  always @(negedge scl) begin
    if (act) begin
      if (bc == 8 && adr_ph) begin
        adr_byte = sh;
        hit = (sh[7:1] == SLAVE_ID) && ack_en;
        sda_oe = hit;
      end else if (bc == 8 && !rdon) begin
        wr_byte = sh;
        nbytes++;
        sda_oe = ack_en;
      end else if (bc == 8) sda_oe = 1'b0;
      else if (bc == 9) begin
        if (adr_ph) rdon = hit && adr_byte[0];
        adr_ph = 1'b0;
        bc = 0;
        sda_oe = rdon && !rd_data[7];
      end else if (rdon) sda_oe = !rd_data[7-bc];
      // Slow answer: hold the clock low after each fall
      if (stretch) begin
        scl_oe = 1'b1;
        #(STRETCH_NS) scl_oe = 1'b0;
      end
    end
  end
endmodule : i2c_slave_model

// [sim/i2c_hardware_master_tb.sv]
// Self-checking bench for the I2C hardware master
`timescale 1ns/1ns
`include "i2c_master_regs.svh"
module i2c_hardware_master_tb;
  import i2c_master_pkg::*;
  localparam logic [6:0] SLV = 7'h3a;
  localparam logic [63:0] RESET_MAP = {`TX_BUF_ADDR, `RX_BUF_ADDR, `MODE_ADDR, `SLAVE_ADDR_ADDR, `STATUS_ADDR, 24'h000000};
  logic       clock, reset, sfr_wr, sfr_rd, serial_port_select, ack_en, stretch;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv, wr_byte, adr_byte, rd_data, tx;
  logic       spi_sclk_out, spi_sclk_oe, spi_mosi_out, spi_mosi_oe;
  logic       scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe;
  logic [15:0] lf;
  wire        scl_w, sda_w;
  int         fails, total_checks, nbytes, starts, stops, rise_n, st0, sp0, nb0;
  time        t0, per;
  // Wired-AND with pull-ups
  assign scl_w = !((scl_oe && !scl_out) || s_scl_oe);
  assign sda_w = !((sda_oe && !sda_out) || s_sda_oe);
  i2c_hardware_master dut_u (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .serial_port_select(serial_port_select),
    .spi_sclk_out(spi_sclk_out), .spi_sclk_oe(spi_sclk_oe), .spi_mosi_out(spi_mosi_out),
    .spi_mosi_oe(spi_mosi_oe), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe));
  i2c_slave_model #(.SLAVE_ID(SLV)) slave_u (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .stretch(stretch),
    .rd_data(rd_data), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .adr_byte(adr_byte), .wr_byte(wr_byte),
    .nbytes(nbytes), .starts(starts), .stops(stops));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge scl_w) begin
    if (rise_n == 0) t0 = $time;
    if (rise_n == 1) per = $time - t0;
    rise_n++;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [31:0] exp_period(input rate_sel_t r);
    return (`SCL_BASE_DIV << r) * 8;
  endfunction : exp_period
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge clock);
    #1 sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge clock);
    #1 sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  task automatic wait_idle;
    int n;
    n = 0;
    rd(`STATUS_ADDR, rv);
    while (rv[`ST_BUSY_BIT] !== 1'b0 && n < 4000) begin
      rd(`STATUS_ADDR, rv);
      n++;
    end
    if (n == 4000) begin
      fails++;
      finish_test();
    end
  endtask : wait_idle
  task automatic xfer(input rate_sel_t r, input logic [4:0] c, input logic d);
    wr(`MODE_ADDR, {1'b1, r, c});
    {st0, sp0, nb0, rise_n} = {starts, stops, nbytes, 32'd0};
    wr(`SLAVE_ADDR_ADDR, {SLV, d});
    wait_idle();
    check(starts - st0, 1);
    check(stops - sp0, 1);
    check(adr_byte, {SLV, d});
    if (!stretch) check(per[31:0], exp_period(r));
    rd(`STATUS_ADDR, rv);
    wr(`STATUS_ADDR, 8'h00);
  endtask : xfer
  initial begin
    #800000 fails++;
    finish_test();
  end
  initial begin
    {reset, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, serial_port_select} = {3'b100, 16'h0000, 1'b1};
    {spi_sclk_out, spi_sclk_oe, spi_mosi_out, spi_mosi_oe, ack_en, stretch} = 6'b000010;
    {rd_data, lf, fails, total_checks, rise_n} = {8'h00, 16'd23278, 96'd0};
    repeat (4) @(posedge clock);
    #1 reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(RESET_MAP[i*8 +: 8], rv);
      check(rv, 8'h00);
    end
    rise_n = 0;
    wr(`SLAVE_ADDR_ADDR, {SLV, 1'b0});
    repeat (100) @(posedge clock);
    check(rise_n, 0);
    rd(`SLAVE_ADDR_ADDR, rv);
    check(rv, {SLV, 1'b0});
    for (int r = 0; r < 4; r++) begin
      lf = lfsr(lf);
      wr(`TX_BUF_ADDR, lf[7:0]);
      xfer(r[1:0], 5'd0, 1'b0);
      check(wr_byte, lf[7:0]);
      check(rv, 8'h10);
    end
    // Second byte into a full buffer is dropped
    lf = lfsr(lf);
    tx = lf[7:0];
    wr(`MODE_ADDR, 8'h00);
    wr(`TX_BUF_ADDR, tx);
    wr(`TX_BUF_ADDR, ~tx);
    rd(`STATUS_ADDR, rv);
    check(rv[3:0], 4'hd);
    wr(`STATUS_ADDR, 8'h00);
    rd(`STATUS_ADDR, rv);
    check(rv[0], 1'b0);
    xfer(2'd1, 5'd0, 1'b0);
    check(wr_byte, tx);
    ack_en = 1'b0;
    wr(`TX_BUF_ADDR, ~tx);
    xfer(2'd0, 5'd0, 1'b0);
    check(nbytes - nb0, 0);
    check(rv[6], 1'b1);
    rd(`STATUS_ADDR, rv);
    check(rv[6], 1'b0);
    ack_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      rd_data = lf[7:0];
      stretch = k[0];
      xfer(2'd1, {k[2:0], 2'b00}, 1'b1);
      check(nbytes - nb0, 4 * k + 1);
      check(rv[5], 1'b1);
      rd(`RX_BUF_ADDR, rv);
      check(rv, rd_data);
    end
    serial_port_select = 1'b0;
    repeat (8) begin
      lf = lfsr(lf);
      @(posedge clock);
      #1 {spi_sclk_out, spi_sclk_oe, spi_mosi_out, spi_mosi_oe} = lf[3:0];
      #2 check({scl_out, scl_oe, sda_out, sda_oe}, lf[3:0]);
    end
    finish_test();
  end
endmodule : i2c_hardware_master_tb
